// file: shared/pldpc_pkg.sv
// Shared constants and carrier types of the phase detector control and lock detect block
package pldpc_pkg;

  // Bus geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int CNT_W = 14;

  // Register offsets
  localparam logic [8:0] ADDR_PD_CTRL = 9'h169;
  localparam logic [8:0] ADDR_CNT_HI = 9'h16A;
  localparam logic [8:0] ADDR_CNT_LO = 9'h16B;
  localparam logic [8:0] ADDR_IRQ_STAT = 9'h170;
  localparam logic [8:0] ADDR_IRQ_MASK = 9'h171;
  localparam logic [8:0] ADDR_LOCK_STAT = 9'h172;
  localparam logic [8:0] ADDR_RUN_CNT_HI = 9'h173;
  localparam logic [8:0] ADDR_RUN_CNT_LO = 9'h174;

  // Phase detector control field positions
  localparam int PDC_WIN_LSB = 5;
  localparam int PDC_GAIN_LSB = 3;
  localparam int PDC_POL_BIT = 2;
  localparam int PDC_HIZ_BIT = 1;
  localparam int PDC_FIXED_BIT = 0;
  localparam logic [7:0] PDC_WMASK = 8'h7F;

  // Count-high register fields
  localparam int CNTH_REQ_EN_BIT = 6;
  localparam logic [7:0] CNTH_WMASK = 8'h7F;
  localparam logic [7:0] CNTH_CNT_MASK = 8'h3F;

  // Reset values
  localparam logic [7:0] RST_PD_CTRL = 8'h59;
  localparam logic [7:0] RST_CNT_HI = 8'h20;
  localparam logic [7:0] RST_CNT_LO = 8'h00;

  // Window codes; only one is a usable window
  localparam logic [1:0] WIN_CODE_3P7NS = 2'h2;
  localparam int WIN_TIME_3P7NS_PS = 3700;

  // Charge pump current codes
  typedef enum logic [1:0] {
    PLDPC_CP_100UA = 2'h0,
    PLDPC_CP_400UA = 2'h1,
    PLDPC_CP_1600UA = 2'h2,
    PLDPC_CP_3200UA = 2'h3
  } pldpc_cp_cur_t;

  // Interrupt bit positions
  localparam int IRQ_W = 3;
  localparam int IRQ_LOCK_GAIN = 0;
  localparam int IRQ_LOCK_LOSS = 1;
  localparam int IRQ_CFG_ERR = 2;

  // Pin synchroniser
  localparam int SYNC_STAGES = 3;
  localparam int PIN_N = 3;
  localparam int PIN_TICK = 0;
  localparam int PIN_WIN = 1;
  localparam int PIN_REQ = 2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } pldpc_bus_req_t;

  typedef struct packed {
    logic [1:0] lock_window_size;
    pldpc_cp_cur_t charge_pump_current_sel;
    logic charge_pump_polarity;
    logic charge_pump_hiz;
  } pldpc_pd_cfg_t;

endpackage

// file: hdl/pldpc_core.sv
// Phase detector control registers, digital lock detect and pulse request gating
// Functional notes
// - The 2-bit lock window field selects the phase window; only code 2 (3.7 ns) is valid.
// - The lock counter advances up to the programmed count, one step per phase detector cycle whose error lies inside the window.
// - Digital lock detect rises only after the programmed number of in-window cycles.
// - The lock count's upper six bits sit in count-high[5:0], the lower eight in count-low.
// - The 2-bit charge pump current code picks 100, 400, 1600 or 3200 uA; 3200 uA is default.
// - The charge pump polarity bit picks negative (0, default) or positive (1) slope.
// - The charge pump high-impedance bit floats the charge pump output when 1, default 0.
// - The pulse request enable bit lets the sync/request pin ask for continuous pulses.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps

module pldpc_core (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire pldpc_pkg::pldpc_bus_req_t bus_i,
  output logic [7:0] rd_data_o,
  // Phase detector side pins
  input wire logic pd_tick_i,
  input wire logic phase_in_window_i,
  input wire logic sync_request_pin_i,
  // Analog controls and status
  output pldpc_pkg::pldpc_pd_cfg_t pd_cfg_o,
  output logic digital_lock_detect_o,
  output logic pulse_request_o,
  // Interrupt
  output logic irq_o
);

  typedef struct packed {
    logic [7:0] pd_ctrl;
    logic [7:0] cnt_hi;
    logic [7:0] cnt_lo;
    logic [pldpc_pkg::IRQ_W-1:0] irq_stat;
    logic [pldpc_pkg::IRQ_W-1:0] irq_mask;
    logic [7:0] rd_data;
    logic [pldpc_pkg::SYNC_STAGES-1:0][pldpc_pkg::PIN_N-1:0] sync;
    logic [pldpc_pkg::PIN_N-1:0] filt;
    logic [pldpc_pkg::CNT_W-1:0] run_cnt;
    logic lock;
    logic irq;
    pldpc_pkg::pldpc_pd_cfg_t pd_cfg;
    logic pulse_req;
  } pldpc_state_t;

  pldpc_state_t state_ff;
  pldpc_state_t nxt_state;

  logic [pldpc_pkg::PIN_N-1:0] pins;
  logic [pldpc_pkg::PIN_N-1:0] settled;
  logic tick_evt;
  logic win_valid;
  logic [pldpc_pkg::CNT_W-1:0] target;
  logic [pldpc_pkg::CNT_W-1:0] cnt_next;
  logic lock_next;
  logic cfg_err_evt;
  logic [7:0] wr_pd_ctrl;
  logic [7:0] wr_cnt_hi;
  logic [7:0] wr_cnt_lo;
  logic [pldpc_pkg::CNT_W-1:0] wr_target;
  logic [pldpc_pkg::IRQ_W-1:0] irq_evt;
  logic [pldpc_pkg::IRQ_W-1:0] irq_clr;
  logic [pldpc_pkg::PIN_N-1:0] filt_next;
  logic [pldpc_pkg::IRQ_W-1:0] stat_next;
  logic sel_pd_ctrl;
  logic sel_cnt_hi;
  logic sel_cnt_lo;
  logic wr_pd_strobe;
  logic wr_cnt_strobe;

  assign pins = {sync_request_pin_i, phase_in_window_i, pd_tick_i};

  // Address decode shared by the contract checks on writes
  assign sel_pd_ctrl = (bus_i.addr == pldpc_pkg::ADDR_PD_CTRL);
  assign sel_cnt_hi = (bus_i.addr == pldpc_pkg::ADDR_CNT_HI);
  assign sel_cnt_lo = (bus_i.addr == pldpc_pkg::ADDR_CNT_LO);
  assign wr_pd_strobe = bus_i.wr && sel_pd_ctrl;
  assign wr_cnt_strobe = bus_i.wr && (sel_cnt_hi || sel_cnt_lo);

  // Pin filters: a new level counts once stages 1 and 2 agree, which rejects
  // a single-cycle glitch at the cost of one more cycle of latency
  for (genvar gi = 0; gi < pldpc_pkg::PIN_N; gi++) begin : g_pin
    assign settled[gi] = (state_ff.sync[1][gi] == state_ff.sync[2][gi]);
    assign filt_next[gi] = settled[gi] ? state_ff.sync[2][gi] : state_ff.filt[gi];
  end

  // Sticky status per bit: a new event wins over a clear in the same cycle
  for (genvar gb = 0; gb < pldpc_pkg::IRQ_W; gb++) begin : g_stat
    assign stat_next[gb] = irq_evt[gb] || (state_ff.irq_stat[gb] && !irq_clr[gb]);
  end

  always_comb begin
    nxt_state = state_ff;

    // Pin synchronisers: stage 0 feeds only stage 1
    nxt_state.sync[0] = pins;
    nxt_state.sync[1] = state_ff.sync[0];
    nxt_state.sync[2] = state_ff.sync[1];
    nxt_state.filt = filt_next;

    // One comparison per rising edge of the phase detector tick
    tick_evt = settled[pldpc_pkg::PIN_TICK] && state_ff.sync[2][pldpc_pkg::PIN_TICK]
               && !state_ff.filt[pldpc_pkg::PIN_TICK];

    // A reserved window code defines no window, so nothing counts as inside it
    win_valid = (state_ff.pd_ctrl[pldpc_pkg::PDC_WIN_LSB +: 2] ==
                 pldpc_pkg::WIN_CODE_3P7NS);

    target = {state_ff.cnt_hi[5:0], state_ff.cnt_lo};

    // Lock counter
    cnt_next = state_ff.run_cnt;
    lock_next = state_ff.lock;
    if (tick_evt) begin
      if (win_valid && state_ff.filt[pldpc_pkg::PIN_WIN]) begin
        if (state_ff.run_cnt < target) begin
          cnt_next = state_ff.run_cnt + 14'h0001;
        end
        // A zero count is invalid and never yields lock
        lock_next = (target != 14'h0000) && (cnt_next >= target);
      end else begin
        cnt_next = '0;
        lock_next = 1'b0;
      end
    end
    nxt_state.run_cnt = cnt_next;
    nxt_state.lock = lock_next;

    // Register writes
    wr_pd_ctrl = state_ff.pd_ctrl;
    wr_cnt_hi = state_ff.cnt_hi;
    wr_cnt_lo = state_ff.cnt_lo;
    irq_clr = '0;
    if (bus_i.wr) begin
      case (bus_i.addr)
        pldpc_pkg::ADDR_PD_CTRL: begin
          // Reserved bit 7 is not stored
          wr_pd_ctrl = bus_i.wdata & pldpc_pkg::PDC_WMASK;
        end
        pldpc_pkg::ADDR_CNT_HI: begin
          wr_cnt_hi = bus_i.wdata & pldpc_pkg::CNTH_WMASK;
        end
        pldpc_pkg::ADDR_CNT_LO: begin
          wr_cnt_lo = bus_i.wdata;
        end
        pldpc_pkg::ADDR_IRQ_STAT: begin
          irq_clr = bus_i.wdata[pldpc_pkg::IRQ_W-1:0];
        end
        pldpc_pkg::ADDR_IRQ_MASK: begin
          nxt_state.irq_mask = bus_i.wdata[pldpc_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    nxt_state.pd_ctrl = wr_pd_ctrl;
    nxt_state.cnt_hi = wr_cnt_hi;
    nxt_state.cnt_lo = wr_cnt_lo;

    // Flag writes that break the programming contract so software can see them
    wr_target = {wr_cnt_hi[5:0], wr_cnt_lo};
    cfg_err_evt = 1'b0;
    if (wr_pd_strobe) begin
      if (!bus_i.wdata[pldpc_pkg::PDC_FIXED_BIT]) begin
        cfg_err_evt = 1'b1;
      end
      if (bus_i.wdata[pldpc_pkg::PDC_WIN_LSB +: 2] != pldpc_pkg::WIN_CODE_3P7NS) begin
        cfg_err_evt = 1'b1;
      end
    end
    if (wr_cnt_strobe) begin
      if (wr_target == 14'h0000) begin
        cfg_err_evt = 1'b1;
      end
    end

    irq_evt = '0;
    irq_evt[pldpc_pkg::IRQ_LOCK_GAIN] = lock_next && !state_ff.lock;
    irq_evt[pldpc_pkg::IRQ_LOCK_LOSS] = !lock_next && state_ff.lock;
    irq_evt[pldpc_pkg::IRQ_CFG_ERR] = cfg_err_evt;
    nxt_state.irq_stat = stat_next;
    nxt_state.irq = |(nxt_state.irq_stat & nxt_state.irq_mask);

    // Analog controls follow the stored control register
    nxt_state.pd_cfg.lock_window_size = wr_pd_ctrl[pldpc_pkg::PDC_WIN_LSB +: 2];
    nxt_state.pd_cfg.charge_pump_current_sel =
      pldpc_pkg::pldpc_cp_cur_t'(wr_pd_ctrl[pldpc_pkg::PDC_GAIN_LSB +: 2]);
    nxt_state.pd_cfg.charge_pump_polarity = wr_pd_ctrl[pldpc_pkg::PDC_POL_BIT];
    nxt_state.pd_cfg.charge_pump_hiz = wr_pd_ctrl[pldpc_pkg::PDC_HIZ_BIT];

    // Pin request passes only while enabled; disabling drops it at once
    nxt_state.pulse_req = wr_cnt_hi[pldpc_pkg::CNTH_REQ_EN_BIT] &&
                          nxt_state.filt[pldpc_pkg::PIN_REQ];

    // Read data stands in the cycle after the read strobe only
    nxt_state.rd_data = 8'h00;
    if (bus_i.rd) begin
      case (bus_i.addr)
        pldpc_pkg::ADDR_PD_CTRL: begin
          nxt_state.rd_data = state_ff.pd_ctrl;
        end
        pldpc_pkg::ADDR_CNT_HI: begin
          nxt_state.rd_data = state_ff.cnt_hi;
        end
        pldpc_pkg::ADDR_CNT_LO: begin
          nxt_state.rd_data = state_ff.cnt_lo;
        end
        pldpc_pkg::ADDR_IRQ_STAT: begin
          nxt_state.rd_data = {5'h00, state_ff.irq_stat};
        end
        pldpc_pkg::ADDR_IRQ_MASK: begin
          nxt_state.rd_data = {5'h00, state_ff.irq_mask};
        end
        pldpc_pkg::ADDR_LOCK_STAT: begin
          nxt_state.rd_data = {5'h00, state_ff.pulse_req, win_valid, state_ff.lock};
        end
        pldpc_pkg::ADDR_RUN_CNT_HI: begin
          nxt_state.rd_data = {2'h0, state_ff.run_cnt[13:8]};
        end
        pldpc_pkg::ADDR_RUN_CNT_LO: begin
          nxt_state.rd_data = state_ff.run_cnt[7:0];
        end
        default: begin
          nxt_state.rd_data = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff.pd_ctrl <= pldpc_pkg::RST_PD_CTRL;
      state_ff.cnt_hi <= pldpc_pkg::RST_CNT_HI;
      state_ff.cnt_lo <= pldpc_pkg::RST_CNT_LO;
      state_ff.irq_stat <= '0;
      state_ff.irq_mask <= '0;
      state_ff.rd_data <= 8'h00;
      state_ff.sync <= '0;
      state_ff.filt <= '0;
      state_ff.run_cnt <= '0;
      state_ff.lock <= 1'b0;
      state_ff.irq <= 1'b0;
      state_ff.pd_cfg.lock_window_size <= pldpc_pkg::RST_PD_CTRL[pldpc_pkg::PDC_WIN_LSB +: 2];
      state_ff.pd_cfg.charge_pump_current_sel <= pldpc_pkg::PLDPC_CP_3200UA;
      state_ff.pd_cfg.charge_pump_polarity <= 1'b0;
      state_ff.pd_cfg.charge_pump_hiz <= 1'b0;
      state_ff.pulse_req <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data_o = state_ff.rd_data;
  assign pd_cfg_o = state_ff.pd_cfg;
  assign digital_lock_detect_o = state_ff.lock;
  assign pulse_request_o = state_ff.pulse_req;
  assign irq_o = state_ff.irq;

endmodule

// file: bench/pldpc_core_properties.sv
// Port-level assertions for the phase detector control and lock detect block
`timescale 1ns/10ps
module pldpc_core_checker (
  // Clock, reset and register port
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire pldpc_pkg::pldpc_bus_req_t bus_i,
  input wire logic [7:0] rd_data_o,
  // Pins and outputs
  input wire logic pd_tick_i,
  input wire logic phase_in_window_i,
  input wire logic sync_request_pin_i,
  input wire pldpc_pkg::pldpc_pd_cfg_t pd_cfg_o,
  input wire logic digital_lock_detect_o,
  input wire logic pulse_request_o,
  input wire logic irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire logic ctl_wr = bus_i.wr && bus_i.addr == pldpc_pkg::ADDR_PD_CTRL;
  AST_CFG_WIN: assert property (ctl_wr |=>
    pd_cfg_o.lock_window_size == $past(bus_i.wdata[6:5])) else $error("window field wrong");
  AST_CFG_GAIN: assert property (ctl_wr |=>
    pd_cfg_o.charge_pump_current_sel == $past(bus_i.wdata[4:3])) else $error("gain wrong");
  AST_CFG_POL: assert property (ctl_wr |=>
    pd_cfg_o.charge_pump_polarity == $past(bus_i.wdata[2])) else $error("polarity wrong");
  AST_CFG_HIZ: assert property (ctl_wr |=>
    pd_cfg_o.charge_pump_hiz == $past(bus_i.wdata[1])) else $error("hiz wrong");
  AST_CFG_HOLD: assert property (!ctl_wr |=> $stable(pd_cfg_o)) else $error("cfg moved");
  AST_RD_CTRL: assert property (bus_i.rd && bus_i.addr == pldpc_pkg::ADDR_PD_CTRL |=>
    rd_data_o[7:1] == {1'b0, $past(pd_cfg_o)}) else $error("ctrl readback wrong");
  AST_LOCK_VALID: assert property ($rose(digital_lock_detect_o) |->
    $past(pd_cfg_o.lock_window_size) == pldpc_pkg::WIN_CODE_3P7NS) else $error("bad lock");
  // Lock is only re-evaluated at a comparison, which trails the tick pin by three edges
  AST_LOCK_AT_TICK: assert property ($changed(digital_lock_detect_o) |->
    $past(pd_tick_i, 3)) else $error("lock moved without tick");
  AST_PULSE_REQ: assert property (pulse_request_o |->
    $past(sync_request_pin_i, 3) || $past(sync_request_pin_i, 4)) else $error("pulse no pin");
endmodule

bind pldpc_core pldpc_core_checker u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus_i),
  .rd_data_o(rd_data_o), .pd_tick_i(pd_tick_i), .phase_in_window_i(phase_in_window_i),
  .sync_request_pin_i(sync_request_pin_i), .pd_cfg_o(pd_cfg_o),
  .digital_lock_detect_o(digital_lock_detect_o), .pulse_request_o(pulse_request_o),
  .irq_o(irq_o));

// file: bench/test_pldpc_core.sv
// Directed testbench for the phase detector control and lock detect block
`timescale 1ns/10ps
module test_pldpc_core;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  pldpc_pkg::pldpc_bus_req_t bus = '0;
  logic tick = 1'b0;
  logic win = 1'b0;
  logic pin = 1'b0;
  logic [7:0] rdat;
  pldpc_pkg::pldpc_pd_cfg_t cfg;
  logic lock;
  logic preq;
  logic irq;
  int error_cnt = 0;
  int n_tests = 0;

  initial forever #25 ref_clk_i = ~ref_clk_i;

  pldpc_core dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus), .rd_data_o(rdat),
    .pd_tick_i(tick), .phase_in_window_i(win), .sync_request_pin_i(pin), .pd_cfg_o(cfg),
    .digital_lock_detect_o(lock), .pulse_request_o(preq), .irq_o(irq));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    bus <= '{1'b1, 1'b0, a, d};
    cyc(1);
    bus <= '0;
    cyc(1);
  endtask
  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    cyc(1);
    bus <= '0;
    #1 chk(rdat, exp);
    cyc(1);
  endtask
  // Window level settles before the tick and is held until the comparison has landed
  task automatic cmp(input logic w);
    win <= w;
    cyc(4);
    tick <= 1'b1;
    cyc(4);
    tick <= 1'b0;
    cyc(5);
  endtask

  task automatic t_reset;
    chk({2'b00, cfg}, 8'h2C);
    rd(9'h169, 8'h59);
    rd(9'h16A, 8'h20);
    rd(9'h16B, 8'h00);
    rd(9'h100, 8'h00);
    chk({5'h00, lock, preq, irq}, 8'h00);
  endtask

  task automatic t_cfg;
    logic [1:0] g;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      g = 2'(i);
      v = {1'b0, 2'h2, g, g[0], g[1], 1'b1};
      wr(9'h169, v);
      chk({2'b00, cfg}, {2'b00, 2'h2, g, g[0], g[1]});
      rd(9'h169, v);
    end
    wr(9'h169, 8'hFF);
    rd(9'h169, 8'h7F);
    chk(8'(cfg.charge_pump_hiz), 8'h01);
    wr(9'h169, 8'h59);
  endtask

  task automatic t_lock;
    wr(9'h171, 8'h07);
    wr(9'h16A, 8'h00);
    wr(9'h16B, 8'h03);
    wr(9'h169, 8'h19);
    repeat (3) cmp(1'b1);
    chk(8'(lock), 8'h00);
    rd(9'h170, 8'h04);
    wr(9'h169, 8'h59);
    wr(9'h170, 8'h07);
    chk(8'(irq), 8'h00);
    wr(9'h169, 8'h58);
    rd(9'h170, 8'h04);
    wr(9'h169, 8'h59);
    wr(9'h170, 8'h07);
    chk(8'(irq), 8'h00);
    cmp(1'b1);
    cmp(1'b1);
    chk(8'(lock), 8'h00);
    rd(9'h174, 8'h02);
    cmp(1'b1);
    chk({6'h00, lock, irq}, 8'h03);
    rd(9'h170, 8'h01);
    wr(9'h171, 8'h02);
    chk(8'(irq), 8'h00);
    cmp(1'b0);
    chk({6'h00, lock, irq}, 8'h01);
    rd(9'h174, 8'h00);
    wr(9'h170, 8'h03);
    chk(8'(irq), 8'h00);
  endtask

  task automatic t_preq;
    wr(9'h16A, 8'hFF);
    rd(9'h16A, 8'h7F);
    // Pulser source is taken as already selected outside this block
    wr(9'h16A, 8'h40);
    pin <= 1'b1;
    cyc(6);
    chk(8'(preq), 8'h01);
    wr(9'h16A, 8'h00);
    chk(8'(preq), 8'h00);
    pin <= 1'b0;
    cyc(6);
  endtask

  task automatic final_report;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard: the directed run needs far fewer cycles than this
  initial begin
    #1000000;
    error_cnt++;
    final_report();
  end

  initial begin
    cyc(2);
    rst_i <= 1'b0;
    cyc(1);
    t_reset();
    t_cfg();
    t_lock();
    t_preq();
    final_report();
  end
endmodule
